// file: ptb_pkg.sv
// Purpose: shared constants for the periodic timebase block
// Assumes: one 50 MHz clock that is also the crystal reference clock
// Notes: register map, field positions, tap table, bus states
package ptb_pkg;

  // Divider chain and pre-divider
  localparam int unsigned PTB_STAGES = 15;
  localparam int unsigned PTB_PREDIV = 128;

  // Register byte offsets
  localparam logic [3:0] PTB_OFS_CTRL = 4'h0;
  localparam logic [3:0] PTB_OFS_STAT = 4'h4;
  localparam logic [3:0] PTB_OFS_MASK = 4'h8;

  // timebase_control fields
  localparam int unsigned PTB_BIT_RUN = 1;
  localparam int unsigned PTB_BIT_IE = 2;
  localparam int unsigned PTB_BIT_ACK = 3;
  localparam int unsigned PTB_TAP_LO = 4;
  localparam int unsigned PTB_BIT_FLAG = 7;

  // Status and mask fields
  localparam int unsigned PTB_ST_ROLL = 0;
  localparam int unsigned PTB_ST_OVR = 1;

  // Reset values
  localparam logic PTB_RST_RUN = 1'b0;
  localparam logic PTB_RST_IE = 1'b0;
  localparam logic [2:0] PTB_RST_TAP = 3'h0;
  localparam logic PTB_RST_MASK_OVR = 1'b0;

  // Chain bit whose rising edge marks the rollover, per tap code.
  // Divisor is two to the power (bit + 1): 32768 down to 8.
  localparam logic [3:0] PTB_TAP_BIT [8] = '{
    4'hE, 4'hC, 4'hA, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2
  };

  typedef enum logic {
    PTB_IDLE = 1'b0,
    PTB_ANSWER = 1'b1
  } ptb_bus_state_t;

endpackage

// file: ptb_prediv.sv
// Purpose: divide-by-N enable pulse generator for the timebase source
// Assumes: clear_i held while the timebase is off
// Notes: tick_o is a one-cycle pulse every DIV enabled cycles
`timescale 1ns/1ps
`default_nettype none
module ptb_prediv #(
  parameter int unsigned DIV = 128
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic clear_i,
  output logic tick_o
);
  localparam int unsigned W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  assign tick_o = en_i & (cnt_q == LAST);
  assign cnt_d = clear_i ? '0 :
                 !en_i ? cnt_q :
                 tick_o ? '0 : cnt_q + W'(1);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // ptb_prediv
`default_nettype wire

// file: ptb_timebase.sv
// Purpose: periodic timebase with rollover flag and interrupt
// Assumes: clk_i is the crystal reference clock; Avalon-MM slave
// Notes: one wait state per access; CPU access void in wait/stop
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ptb_timebase
  import ptb_pkg::*;
#(
  parameter int unsigned STAGES = PTB_STAGES,
  parameter int unsigned PREDIV = PTB_PREDIV
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic prediv128_select_i,
  input wire logic osc_keep_in_stop_i,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  output logic irq_o,
  output logic stop_wakeup_o
);

  // Bus slave
  ptb_bus_state_t state_q;
  ptb_bus_state_t state_d;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;

  logic req;
  logic answer;
  logic cpu_blocked;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  // Control and state
  logic run_q;
  logic ie_q;
  logic [2:0] tap_q;
  logic flag_q;
  logic ovr_q;
  logic mask_ovr_q;
  logic [STAGES-1:0] cnt_q;

  logic run_d;
  logic ie_d;
  logic [2:0] tap_d;
  logic flag_d;
  logic ovr_d;
  logic mask_ovr_d;
  logic [STAGES-1:0] cnt_d;

  logic clk_alive;
  logic pre_tick;
  logic src_tick;
  logic step;
  logic [STAGES-1:0] cnt_inc;
  logic [3:0] tap_bit;
  logic rollover;
  logic clr_ack;
  logic clr_st_roll;
  logic clr_st_ovr;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;
  logic [7:0] mask_rd;

  // Handshake: first cycle stalls, second cycle answers
  assign req = avs_read_i | avs_write_i;
  assign answer = req & (state_q == PTB_ANSWER);
  assign avs_waitrequest_o = req & (state_q == PTB_IDLE);
  assign avs_readdata_o = readdata_q;

  // Access still completes so the bus never hangs in low power
  assign cpu_blocked = wait_mode_i | stop_mode_i;
  assign wr_ok = avs_write_i & answer & ~cpu_blocked & avs_byteenable_i[0];
  assign wr_ctrl = wr_ok & (avs_address_i == PTB_OFS_CTRL);
  assign wr_stat = wr_ok & (avs_address_i == PTB_OFS_STAT);
  assign wr_mask = wr_ok & (avs_address_i == PTB_OFS_MASK);

  always_comb begin
    case (state_q)
      PTB_IDLE: state_d = req ? PTB_ANSWER : PTB_IDLE;
      PTB_ANSWER: state_d = PTB_IDLE;
      default: state_d = PTB_IDLE;
    endcase
  end

  // Readback images; acknowledge slot always zero
  assign ctrl_rd = {flag_q, tap_q, 1'b0, ie_q, run_q, 1'b0};
  assign stat_rd = {6'h00, ovr_q, flag_q};
  assign mask_rd = {6'h00, mask_ovr_q, ie_q};

  always_comb begin
    readdata_d = readdata_q;
    if (avs_read_i && state_q == PTB_IDLE) begin
      if (cpu_blocked) begin
        readdata_d = 32'h0000_0000;
      end else if (avs_address_i == PTB_OFS_CTRL) begin
        readdata_d = {24'h00_0000, ctrl_rd};
      end else if (avs_address_i == PTB_OFS_STAT) begin
        readdata_d = {24'h00_0000, stat_rd};
      end else if (avs_address_i == PTB_OFS_MASK) begin
        readdata_d = {24'h00_0000, mask_rd};
      end else begin
        readdata_d = 32'h0000_0000;
      end
    end
  end

  // Chain source: stop without oscillator freezes everything
  assign clk_alive = ~(stop_mode_i & ~osc_keep_in_stop_i);

  ptb_prediv #(
    .DIV(PREDIV)
  ) u_prediv (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .en_i(run_q & clk_alive),
    .clear_i(~run_q),
    .tick_o(pre_tick)
  );

  // Options are live inputs, expected static while running
  assign src_tick = prediv128_select_i ? pre_tick : 1'b1;
  assign step = run_q & clk_alive & src_tick;
  assign cnt_inc = cnt_q + STAGES'(1);
  assign tap_bit = PTB_TAP_BIT[tap_q];

  // Rising edge of the tap bit: first after half, then every period
  assign rollover = step & cnt_inc[tap_bit] & ~cnt_q[tap_bit];

  assign cnt_d = !run_q ? '0 : (step ? cnt_inc : cnt_q);

  // Acknowledge via control write or via status write-one
  assign clr_ack = wr_ctrl & avs_writedata_i[PTB_BIT_ACK];
  assign clr_st_roll = wr_stat & avs_writedata_i[PTB_ST_ROLL];
  assign clr_st_ovr = wr_stat & avs_writedata_i[PTB_ST_OVR];

  // Set wins over a clear in the same cycle
  assign flag_d = rollover | (flag_q & ~(clr_ack | clr_st_roll));
  assign ovr_d = (rollover & flag_q) | (ovr_q & ~clr_st_ovr);

  // Tap select is not locked; changing it while running is unsafe
  assign run_d = wr_ctrl ? avs_writedata_i[PTB_BIT_RUN] : run_q;
  assign tap_d = wr_ctrl ? avs_writedata_i[PTB_TAP_LO +: 3] : tap_q;
  assign ie_d = wr_ctrl ? avs_writedata_i[PTB_BIT_IE] :
                wr_mask ? avs_writedata_i[PTB_ST_ROLL] : ie_q;
  assign mask_ovr_d = wr_mask ? avs_writedata_i[PTB_ST_OVR] : mask_ovr_q;

  assign irq_o = (flag_q & ie_q) | (ovr_q & mask_ovr_q);
  assign stop_wakeup_o = stop_mode_i & irq_o;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= PTB_IDLE;
      readdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      readdata_q <= readdata_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q <= PTB_RST_RUN;
      ie_q <= PTB_RST_IE;
      tap_q <= PTB_RST_TAP;
      mask_ovr_q <= PTB_RST_MASK_OVR;
    end else begin
      run_q <= run_d;
      ie_q <= ie_d;
      tap_q <= tap_d;
      mask_ovr_q <= mask_ovr_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      flag_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      flag_q <= flag_d;
      ovr_q <= ovr_d;
    end
  end

  // Checks
  logic run_ok;
  assign run_ok = run_q & clk_alive & ~prediv128_select_i & ~wr_ctrl;

  sequence s_run_start_tap7;
    $rose(run_q) && tap_q == 3'h7 && run_ok;
  endsequence

  sequence s_half_period_tap7;
    (!rollover && run_ok)[*3] ##1 rollover;
  endsequence

  property p_hold_zero;
    @(posedge clk_i) disable iff (!rst_b_i)
      !run_q |=> cnt_q == '0;
  endproperty
  a_hold_zero: assert property (p_hold_zero)
    else $error("chain not held at zero while stopped");

  property p_flag_set;
    @(posedge clk_i) disable iff (!rst_b_i)
      rollover |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("rollover did not set pending flag");

  property p_irq_level;
    @(posedge clk_i) disable iff (!rst_b_i)
      flag_q && ie_q |-> irq_o;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt missing with flag and enable set");

  property p_ack_clear;
    @(posedge clk_i) disable iff (!rst_b_i)
      clr_ack && !rollover |=> !flag_q;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("acknowledge did not clear flag");

  property p_ack_reads_zero;
    @(posedge clk_i) disable iff (!rst_b_i)
      avs_read_i && state_q == PTB_IDLE && avs_address_i == PTB_OFS_CTRL
      |=> avs_readdata_o[PTB_BIT_ACK] == 1'b0;
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero)
    else $error("acknowledge bit read back nonzero");

  property p_flag_stable;
    @(posedge clk_i) disable iff (!rst_b_i)
      !rollover && !clr_ack && !clr_st_roll |=> flag_q == $past(flag_q);
  endproperty
  a_flag_stable: assert property (p_flag_stable)
    else $error("flag changed without rollover or acknowledge");

  property p_first_half;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_run_start_tap7 |-> s_half_period_tap7;
  endproperty
  a_first_half: assert property (p_first_half)
    else $error("first rollover not at half period");

  property p_full_period;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rollover && tap_q == 3'h7 && run_ok)
      ##1 (run_ok && tap_q == 3'h7)[*8] |-> rollover;
  endproperty
  a_full_period: assert property (p_full_period)
    else $error("rollover period not eight cycles at tap 7");

  property p_stop_freeze;
    @(posedge clk_i) disable iff (!rst_b_i)
      stop_mode_i && !osc_keep_in_stop_i && run_q
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze)
    else $error("chain advanced in stop without oscillator");

  property p_blocked_write;
    @(posedge clk_i) disable iff (!rst_b_i)
      avs_write_i && answer && cpu_blocked
      |=> run_q == $past(run_q) && tap_q == $past(tap_q)
          && ie_q == $past(ie_q);
  endproperty
  a_blocked_write: assert property (p_blocked_write)
    else $error("register written during wait or stop");

  property p_wakeup;
    @(posedge clk_i) disable iff (!rst_b_i)
      stop_mode_i && flag_q && ie_q |-> stop_wakeup_o;
  endproperty
  a_wakeup: assert property (p_wakeup)
    else $error("no wakeup with pending interrupt in stop");

  property p_irq_source;
    @(posedge clk_i) disable iff (!rst_b_i)
      !flag_q && !ovr_q |-> !irq_o;
  endproperty
  a_irq_source: assert property (p_irq_source)
    else $error("interrupt raised with no pending flag");

  property p_run_step;
    @(posedge clk_i) disable iff (!rst_b_i)
      run_q && clk_alive && !prediv128_select_i
      |=> cnt_q == $past(cnt_inc);
  endproperty
  a_run_step: assert property (p_run_step)
    else $error("chain did not advance on the source clock");

  // Between pre-divider ticks the chain must not move
  property p_prediv_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      run_q && prediv128_select_i && !pre_tick
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_prediv_hold: assert property (p_prediv_hold)
    else $error("chain moved between pre-divider ticks");

  property p_wait_counts;
    @(posedge clk_i) disable iff (!rst_b_i)
      wait_mode_i && !stop_mode_i && run_q && !prediv128_select_i
      |=> cnt_q != $past(cnt_q);
  endproperty
  a_wait_counts: assert property (p_wait_counts)
    else $error("chain stalled in wait mode");

  property p_blocked_read;
    @(posedge clk_i) disable iff (!rst_b_i)
      avs_read_i && state_q == PTB_IDLE && cpu_blocked
      |=> avs_readdata_o == 32'h0000_0000;
  endproperty
  a_blocked_read: assert property (p_blocked_read)
    else $error("register readable during wait or stop");

  property p_wake_in_stop;
    @(posedge clk_i) disable iff (!rst_b_i)
      !stop_mode_i |-> !stop_wakeup_o;
  endproperty
  a_wake_in_stop: assert property (p_wake_in_stop)
    else $error("wakeup raised outside stop mode");

endmodule // ptb_timebase
`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench for the periodic timebase block
// Assumes: one 50 MHz clock; registers reached over Avalon-MM
// Notes: a rising-edge monitor checks read answers and flag periods
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("[FAIL] %0t %s", $time, m); \
  end \
end
module tb;
  import ptb_pkg::*;
  localparam int LIMIT = 90000;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic prediv128_select_i = 1'b0;
  logic osc_keep_in_stop_i = 1'b0;
  logic wait_mode_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, irq_o, stop_wakeup_o, irq_prev = 1'b0;
  int fail_count = 0, n_checks = 0, cyc = 0, t_last = 0, seed = 80;
  int exp_p, r;
  int wait_n = 0;
  int dv[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
  logic [33:0] exp_rd, e;
  logic [33:0] got;
  logic [33:0] rd_q[$];
  int rise_q[$];

  ptb_timebase #(.STAGES(PTB_STAGES), .PREDIV(PTB_PREDIV)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .prediv128_select_i(prediv128_select_i),
    .osc_keep_in_stop_i(osc_keep_in_stop_i),
    .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i),
    .irq_o(irq_o), .stop_wakeup_o(stop_wakeup_o)
  );

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      end_of_test();
    end
  end

  // Sampled at the rising edge, before that edge's updates land
  always @(posedge clk_i) begin
    if (avs_read_i || avs_write_i) begin
      if (avs_waitrequest_o === 1'b0) begin
        `CHK(wait_n, 1, "wait states")
        wait_n = 0;
      end else begin
        wait_n++;
      end
    end
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      exp_rd = rd_q.pop_front();
      got = {irq_o, stop_wakeup_o, avs_readdata_o};
      `CHK(got, exp_rd, "read answer")
    end
    if (irq_o === 1'b1 && irq_prev !== 1'b1) begin
      if (rise_q.size() > 0) begin
        exp_p = rise_q.pop_front();
        `CHK(cyc - t_last, exp_p, "period")
      end
      t_last = cyc;
    end
    irq_prev = irq_o;
  end

  // One idle cycle between transfers avoids double drives
  task automatic bus(input logic is_wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    if (is_wr)
      avs_write_i <= 1'b1;
    else
      avs_read_i <= 1'b1;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'h1);
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] x);
    rd_q.push_back(x);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  // Second write covers a rollover landing on the first one
  task automatic off();
    wr(PTB_OFS_CTRL, 8'h08);
    wr(PTB_OFS_CTRL, 8'h08);
  endtask

  task automatic period(input logic [2:0] t, input int d, input int f);
    rise_q.push_back(f);
    rise_q.push_back(d);
    wr(PTB_OFS_CTRL, {1'b0, t, 4'h6});
    t_last = cyc + 1;
    while (irq_o !== 1'b1) @(posedge clk_i);
    wr(PTB_OFS_CTRL, {1'b0, t, 4'hE});
    @(posedge clk_i);
    while (irq_o !== 1'b1) @(posedge clk_i);
    off();
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(PTB_OFS_CTRL, 34'h0);
    rd(PTB_OFS_STAT, 34'h0);
    rd(PTB_OFS_MASK, 34'h0);
    rd(4'hC, 34'h0);
    $display("test 1 done");
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      e = {26'h0, 1'b0, r[2:0], 1'b0, i[0], 2'b00};
      bus(1'b1, PTB_OFS_CTRL, {r[31:8], 1'b1, r[2:0], 1'b1, i[0], 2'b01},
          4'h1);
      rd(PTB_OFS_CTRL, e);
      rd(PTB_OFS_MASK, {33'h0, i[0]});
    end
    bus(1'b1, PTB_OFS_CTRL, 32'hFF, 4'h0);
    bus(1'b1, 4'hC, r, 4'hF);
    rd(PTB_OFS_CTRL, e);
    $display("test 2 done");
    for (int t = 0; t < 8; t++)
      period(t[2:0], dv[t], dv[t] / 2);
    prediv128_select_i <= 1'b1;
    period(3'h7, 1024, 512);
    prediv128_select_i <= 1'b0;
    $display("test 3 done");
    wr(PTB_OFS_CTRL, 8'h72);
    repeat (5) @(posedge clk_i);
    wr(PTB_OFS_CTRL, 8'h70);
    rd(PTB_OFS_CTRL, 34'hF0);
    rd(PTB_OFS_STAT, 34'h1);
    wr(PTB_OFS_CTRL, 8'h74);
    rd(PTB_OFS_CTRL, {2'b10, 32'hF4});
    wr(PTB_OFS_CTRL, 8'h7C);
    rd(PTB_OFS_CTRL, 34'h74);
    wr(PTB_OFS_CTRL, 8'h72);
    repeat (20) @(posedge clk_i);
    wr(PTB_OFS_CTRL, 8'h70);
    wr(PTB_OFS_MASK, 8'h02);
    rd(PTB_OFS_STAT, {2'b10, 32'h3});
    wr(PTB_OFS_STAT, 8'h01);
    rd(PTB_OFS_STAT, {2'b10, 32'h2});
    wr(PTB_OFS_STAT, 8'h02);
    rd(PTB_OFS_STAT, 34'h0);
    wr(PTB_OFS_MASK, 8'h00);
    $display("test 4 done");
    wr(PTB_OFS_CTRL, 8'h76);
    wait_mode_i <= 1'b1;
    wr(PTB_OFS_CTRL, 8'h08);
    rd(PTB_OFS_CTRL, {2'b10, 32'h0});
    wait_mode_i <= 1'b0;
    off();
    wr(PTB_OFS_CTRL, 8'h76);
    stop_mode_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rd(PTB_OFS_CTRL, 34'h0);
    stop_mode_i <= 1'b0;
    off();
    osc_keep_in_stop_i <= 1'b1;
    wr(PTB_OFS_CTRL, 8'h76);
    stop_mode_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rd(PTB_OFS_CTRL, {2'b11, 32'h0});
    stop_mode_i <= 1'b0;
    osc_keep_in_stop_i <= 1'b0;
    off();
    $display("test 5 done");
    wr(PTB_OFS_CTRL, 8'h76);
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(PTB_OFS_CTRL, 34'h0);
    rd(PTB_OFS_STAT, 34'h0);
    $display("test 6 done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
